// File: design/pdrx_pkg.sv
// Purpose: Shared constants and the state type of the PD receive status and acknowledge timer block.
// Assumes: 100 MHz device clock; registers are eight bits wide at their printed addresses.
// Notes: The state struct is registered as a whole by the block.
package pdrx_pkg;

  localparam logic [15:0] PDRX_OFF_LINE_STAT = 16'h1a44;
  localparam logic [15:0] PDRX_OFF_PKT_STAT = 16'h1a45;
  localparam logic [15:0] PDRX_OFF_ACK_WAIT = 16'h1a46;

  localparam logic [7:0] PDRX_LINE_STAT_RST = 8'h00;
  localparam logic [7:0] PDRX_PKT_STAT_RST = 8'h00;
  localparam logic [7:0] PDRX_ACK_WAIT_RST = 8'h64;
  localparam logic [7:0] PDRX_MAX_SIZE_RST = 8'h22;

  localparam logic [7:0] PDRX_STAT_NONE = 8'h00;
  localparam logic [7:0] PDRX_STAT_UNKNOWN = 8'hff;
  localparam logic [7:0] PDRX_STAT_MASK = 8'h7f;

  localparam int PDRX_LINE_BUSY_BIT = 0;
  localparam int PDRX_RX_ACTIVE_BIT = 1;
  localparam int PDRX_BAD_CRC_BIT = 0;
  localparam int PDRX_DUP_BIT = 1;
  localparam int PDRX_REPLY_BIT = 2;
  localparam int PDRX_OVER_SIZE_BIT = 3;
  localparam int PDRX_FIFO_FULL_BIT = 4;
  localparam int PDRX_SYM_BIT = 5;
  localparam int PDRX_ODD_BIT = 6;

  localparam int PDRX_CLK_PERIOD_NS = 10;
  localparam int PDRX_TICK_NS = 1000;
  localparam int PDRX_TICK_CYCLES = PDRX_TICK_NS / PDRX_CLK_PERIOD_NS;
  localparam int PDRX_ACK_UNIT_US = 10;
  localparam int PDRX_CRC_BYTES = 4;

  typedef struct packed {
    logic [6:0] div;
    logic tick;
    logic [7:0] line_stat;
    logic [7:0] pkt_stat;
    logic [7:0] ack_val;
    logic [7:0] rdata;
    logic in_pkt;
    logic [8:0] byte_cnt;
    logic overrun;
    logic wait_ack;
    logic [11:0] ack_cnt;
    logic ack_timeout;
    logic retry_req;
    logic bad_pkt_irq;
    logic overrun_irq;
    logic dropped_irq;
    logic reply_irq;
    logic tx_start;
    logic tx_aborted;
    logic [7:0] buf0;
    logic [7:0] buf1;
    logic v0;
    logic v1;
  } pdrx_state_t;

endpackage

// File: design/pdrx_status_timer.sv
// Purpose: Receive line status, sticky received-packet error status and the acknowledge wait timer.
// Assumes: All inputs are synchronous to mclk_i; packet events come from the receive framer as pulses.
// Notes: Received bytes pass through a two-entry buffer; a byte that meets a full buffer is an overrun.
//
// Behaviour
// - Line-activity bit reads 0 when the line is idle, 1 when busy.
// - Receiver-active bit 1 is set only while busy and own transmitter idle.
// - Contention is checked at the last moment; a busy line aborts and flags.
// - Packet status is kept only while auto response or auto retry is enabled.
// - Once any status bit is set, the field is frozen until software clears it.
// - Status 0x00 means no errors, 0xFF means unknown, others decode by bit.
// - No status bit exists for a matching acknowledge; transmit success shows it.
// - Hardware sets status bits, software clears by ones; several may set together.
// - Odd nibble count drops the packet, sets bit 6, raises bad-packet interrupt.
// - Symbol error without CRC failure sets bit 5 and the bad-packet interrupt.
// - When oversize bit 3 is set, bits 6, 5 and 0 stay clear.
// - Full FIFO at start or during data drops packet, sets bit 4, overrun interrupt.
// - Packet above the maximum size is dropped, sets bit 3, bad-packet interrupt.
// - Non-acknowledge, non-ping reply while awaiting acknowledge sets bit 2, protocol interrupt.
// - Duplicate packet in auto response sets bit 1 and the dropped interrupt.
// - CRC failure sets bit 0, also forced by symbol error or odd nibbles.
// - Only hardware sets status bits; software clears each by writing one.
// - Acknowledge wait is an 8-bit value in 10 us units, reset 64h.
// - The wait counts a free-running 1 us tick, so it may end 1 us early.
// - Packet length, CRC included, is compared with the maximum size, reset 22h.
`timescale 1ns/1ps

module pdrx_status_timer
  import pdrx_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic line_busy_i,
  input wire logic tx_active_i,
  input wire logic tx_launch_i,
  output logic tx_start_o,
  output logic tx_aborted_o,
  input wire logic auto_resp_en_i,
  input wire logic auto_retry_en_i,
  input wire logic [7:0] rx_max_size_i,
  input wire logic sop_i,
  input wire logic eop_i,
  input wire logic crc_fail_i,
  input wire logic symbol_fault_i,
  input wire logic odd_nibble_i,
  input wire logic duplicate_i,
  input wire logic unexpected_reply_i,
  input wire logic rx_fifo_full_i,
  input wire logic rx_valid_i,
  input wire logic [DATA_W-1:0] rx_data_i,
  output logic rx_ready_o,
  output logic out_valid_o,
  output logic [DATA_W-1:0] out_data_o,
  input wire logic out_ready_i,
  input wire logic tx_end_i,
  input wire logic ack_ok_i,
  output logic ack_timeout_o,
  output logic retry_req_o,
  output logic bad_packet_interrupt_o,
  output logic buffer_overrun_interrupt_o,
  output logic packet_dropped_interrupt_o,
  output logic protocol_error_interrupt_o
);

  localparam logic [6:0] TICK_LAST = 7'(PDRX_TICK_CYCLES - 1);
  localparam logic [11:0] ACK_UNIT = 12'(PDRX_ACK_UNIT_US);
  localparam logic [8:0] CRC_LEN = 9'(PDRX_CRC_BYTES);

  pdrx_state_t st_reg;
  pdrx_state_t st_next;

  logic status_en;
  logic [7:0] clr_mask;
  logic [7:0] kept;
  logic [7:0] set_bits;
  logic oversize;
  logic push;
  logic pop;
  logic [11:0] ack_limit;

  assign status_en = auto_resp_en_i | auto_retry_en_i;
  assign ack_limit = 12'(st_reg.ack_val) * ACK_UNIT;

  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.ack_timeout = 1'b0;
    st_next.retry_req = 1'b0;
    st_next.bad_pkt_irq = 1'b0;
    st_next.overrun_irq = 1'b0;
    st_next.dropped_irq = 1'b0;
    st_next.reply_irq = 1'b0;
    st_next.tx_start = 1'b0;
    st_next.tx_aborted = 1'b0;
    set_bits = PDRX_STAT_NONE;
    oversize = 1'b0;

    // Free-running 1 us tick; the wait may therefore end up to one tick early.
    if (st_reg.div == TICK_LAST)
    begin
      st_next.div = 7'h00;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.div = st_reg.div + 7'h01;
    end

    st_next.line_stat = PDRX_LINE_STAT_RST;
    st_next.line_stat[PDRX_LINE_BUSY_BIT] = line_busy_i;
    st_next.line_stat[PDRX_RX_ACTIVE_BIT] = line_busy_i & ~tx_active_i;

    // The line is sampled at launch, the latest moment before driving it.
    if (tx_launch_i)
    begin
      st_next.tx_start = ~line_busy_i;
      st_next.tx_aborted = line_busy_i;
    end

    // Two-entry buffer: entry 0 is the head shown at the output.
    pop = st_reg.v0 & out_ready_i;
    push = rx_valid_i & ~st_reg.v1;
    if (pop)
    begin
      st_next.buf0 = st_reg.buf1;
      st_next.v0 = st_reg.v1;
      st_next.v1 = 1'b0;
    end
    if (push)
    begin
      if (!st_next.v0)
      begin
        st_next.buf0 = rx_data_i;
        st_next.v0 = 1'b1;
      end
      else
      begin
        st_next.buf1 = rx_data_i;
        st_next.v1 = 1'b1;
      end
    end

    // Packet framing: count bytes and note any overrun.
    if (sop_i)
    begin
      st_next.in_pkt = 1'b1;
      st_next.byte_cnt = 9'h000;
      st_next.overrun = rx_fifo_full_i | st_reg.v1;
    end
    else if (st_reg.in_pkt && rx_valid_i)
    begin
      if (st_reg.byte_cnt != 9'h1ff)
      begin
        st_next.byte_cnt = st_reg.byte_cnt + 9'h001;
      end
      if (st_reg.v1 || rx_fifo_full_i)
      begin
        st_next.overrun = 1'b1;
      end
    end

    // The maximum size already counts the CRC bytes.
    oversize = st_reg.byte_cnt > {1'b0, rx_max_size_i};
    if (eop_i && st_reg.in_pkt)
    begin
      st_next.in_pkt = 1'b0;
      if (oversize)
      begin
        set_bits[PDRX_OVER_SIZE_BIT] = 1'b1;
      end
      else
      begin
        set_bits[PDRX_BAD_CRC_BIT] = crc_fail_i | symbol_fault_i | odd_nibble_i;
        set_bits[PDRX_SYM_BIT] = symbol_fault_i & ~crc_fail_i;
        set_bits[PDRX_ODD_BIT] = odd_nibble_i;
      end
      set_bits[PDRX_FIFO_FULL_BIT] = st_reg.overrun | rx_fifo_full_i;
      set_bits[PDRX_DUP_BIT] = duplicate_i & auto_resp_en_i;
      set_bits[PDRX_REPLY_BIT] = unexpected_reply_i & st_reg.wait_ack;
      st_next.bad_pkt_irq = set_bits[PDRX_OVER_SIZE_BIT] | set_bits[PDRX_BAD_CRC_BIT];
      st_next.overrun_irq = set_bits[PDRX_FIFO_FULL_BIT];
      st_next.dropped_irq = set_bits[PDRX_DUP_BIT];
      st_next.reply_irq = set_bits[PDRX_REPLY_BIT];
    end

    // Write-one clear; a new status is taken only into an empty field and wins over the clear.
    clr_mask = (reg_wr_i && reg_addr_i == PDRX_OFF_PKT_STAT) ? reg_wdata_i : 8'h00;
    kept = st_reg.pkt_stat & ~clr_mask;
    if (status_en && kept == PDRX_STAT_NONE && (set_bits & PDRX_STAT_MASK) != PDRX_STAT_NONE)
    begin
      st_next.pkt_stat = set_bits & PDRX_STAT_MASK;
    end
    else
    begin
      st_next.pkt_stat = kept;
    end

    if (reg_wr_i && reg_addr_i == PDRX_OFF_ACK_WAIT)
    begin
      st_next.ack_val = reg_wdata_i;
    end

    // Acknowledge wait: armed by the end of a transmission, stopped by a good acknowledge.
    if (tx_end_i)
    begin
      st_next.wait_ack = 1'b1;
      st_next.ack_cnt = 12'h000;
    end
    else if (ack_ok_i)
    begin
      st_next.wait_ack = 1'b0;
    end
    else if (st_reg.wait_ack && st_reg.tick)
    begin
      if (st_reg.ack_cnt + 12'h001 >= ack_limit)
      begin
        st_next.wait_ack = 1'b0;
        st_next.ack_timeout = 1'b1;
        st_next.retry_req = auto_retry_en_i;
      end
      else
      begin
        st_next.ack_cnt = st_reg.ack_cnt + 12'h001;
      end
    end

    if (reg_rd_i)
    begin
      case (reg_addr_i)
        PDRX_OFF_LINE_STAT: st_next.rdata = st_reg.line_stat;
        PDRX_OFF_PKT_STAT: st_next.rdata = status_en ? st_reg.pkt_stat : PDRX_STAT_UNKNOWN;
        PDRX_OFF_ACK_WAIT: st_next.rdata = st_reg.ack_val;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_reg <= '0;
      st_reg.line_stat <= PDRX_LINE_STAT_RST;
      st_reg.pkt_stat <= PDRX_PKT_STAT_RST;
      st_reg.ack_val <= PDRX_ACK_WAIT_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign tx_start_o = st_reg.tx_start;
  assign tx_aborted_o = st_reg.tx_aborted;
  assign rx_ready_o = ~st_reg.v1;
  assign out_valid_o = st_reg.v0;
  assign out_data_o = st_reg.buf0;
  assign ack_timeout_o = st_reg.ack_timeout;
  assign retry_req_o = st_reg.retry_req;
  assign bad_packet_interrupt_o = st_reg.bad_pkt_irq;
  assign buffer_overrun_interrupt_o = st_reg.overrun_irq;
  assign packet_dropped_interrupt_o = st_reg.dropped_irq;
  assign protocol_error_interrupt_o = st_reg.reply_irq;

  property p_line_busy;
    @(posedge mclk_i) disable iff (!rstn_i)
    ##1 st_reg.line_stat[PDRX_LINE_BUSY_BIT] == $past(line_busy_i);
  endproperty
  a_line_busy: assert property (p_line_busy) else $error("Line-activity bit does not follow the line.");

  property p_rx_active;
    @(posedge mclk_i) disable iff (!rstn_i)
    (line_busy_i && tx_active_i) |=> !st_reg.line_stat[PDRX_RX_ACTIVE_BIT];
  endproperty
  a_rx_active: assert property (p_rx_active) else $error("Receiver shown active while transmitting.");

  property p_contention;
    @(posedge mclk_i) disable iff (!rstn_i)
    (tx_launch_i && line_busy_i) |=> (tx_aborted_o && !tx_start_o) ##1 !tx_aborted_o;
  endproperty
  a_contention: assert property (p_contention) else $error("Busy line did not abort the launch.");

  property p_disabled;
    @(posedge mclk_i) disable iff (!rstn_i)
    (!status_en && st_reg.pkt_stat == PDRX_STAT_NONE) |=> st_reg.pkt_stat == PDRX_STAT_NONE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Status changed with auto modes off.");

  property p_sticky;
    @(posedge mclk_i) disable iff (!rstn_i)
    ((st_reg.pkt_stat & ~clr_mask) != PDRX_STAT_NONE) |=> (st_reg.pkt_stat & ~$past(st_reg.pkt_stat)) == 8'h00;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Set status field was updated by hardware.");

  property p_oversize_excl;
    @(posedge mclk_i) disable iff (!rstn_i)
    st_reg.pkt_stat[PDRX_OVER_SIZE_BIT] |-> (st_reg.pkt_stat & 8'h61) == 8'h00;
  endproperty
  a_oversize_excl: assert property (p_oversize_excl) else $error("CRC-class bit set with oversize.");

  property p_crc_forced;
    @(posedge mclk_i) disable iff (!rstn_i)
    (eop_i && st_reg.in_pkt && status_en && st_reg.pkt_stat == PDRX_STAT_NONE && !clr_mask[0]
      && !oversize && (symbol_fault_i || odd_nibble_i))
    |=> st_reg.pkt_stat[PDRX_BAD_CRC_BIT] && bad_packet_interrupt_o;
  endproperty
  a_crc_forced: assert property (p_crc_forced) else $error("Bad CRC bit not forced.");

  property p_odd;
    @(posedge mclk_i) disable iff (!rstn_i)
    (eop_i && st_reg.in_pkt && odd_nibble_i && !oversize) |=> bad_packet_interrupt_o;
  endproperty
  a_odd: assert property (p_odd) else $error("Odd nibbles did not raise bad-packet.");

  property p_overrun;
    @(posedge mclk_i) disable iff (!rstn_i)
    (eop_i && st_reg.in_pkt && st_reg.overrun) |=> buffer_overrun_interrupt_o;
  endproperty
  a_overrun: assert property (p_overrun) else $error("Overrun not reported at packet end.");

  property p_w1c;
    @(posedge mclk_i) disable iff (!rstn_i)
    (reg_wr_i && reg_addr_i == PDRX_OFF_PKT_STAT && !eop_i) |=> (st_reg.pkt_stat & $past(reg_wdata_i)) == 8'h00;
  endproperty
  a_w1c: assert property (p_w1c) else $error("Written ones did not clear status.");

  property p_timeout;
    @(posedge mclk_i) disable iff (!rstn_i)
    ack_timeout_o |-> $past(st_reg.ack_cnt) + 12'h001 >= $past(ack_limit) && $past(st_reg.tick);
  endproperty
  a_timeout: assert property (p_timeout) else $error("Acknowledge wait ended early.");

  property p_retry;
    @(posedge mclk_i) disable iff (!rstn_i)
    retry_req_o |-> ack_timeout_o;
  endproperty
  a_retry: assert property (p_retry) else $error("Retry without a timed-out wait.");

endmodule

// File: tb/pdrx_far_model.sv
// Purpose: Receive framer model that feeds packets into the block and drains its byte stream.
// Assumes: Driven on the falling edge of mclk_i.
// Notes: Flags are {crc, symbol, odd, duplicate, reply}; released lines show inverted values.
`timescale 1ns/1ps
module pdrx_far_model
(
  input wire logic mclk_i,
  input wire logic out_valid_i,
  input wire logic [7:0] out_data_i,
  output logic sop_o,
  output logic eop_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic [4:0] flag_o,
  output logic fifo_full_o,
  output logic out_ready_o
);
  logic [7:0] got_q[$];
  initial
  begin
    {sop_o, eop_o, rx_valid_o, fifo_full_o, out_ready_o} = 5'b0_0001;
    rx_data_o = 8'h5a;
    flag_o = 5'h1f;
  end
  always @(posedge mclk_i)
  begin
    if (out_valid_i && out_ready_o)
      got_q.push_back(out_data_i);
  end
  task automatic stall(input logic s);
    out_ready_o = ~s;
  endtask
  // The wire cannot be held off, so a byte comes every cycle whatever the buffer says.
  task automatic send_pkt(input int nb, input logic [4:0] fl, input logic full);
    sop_o = 1'b1;
    @(negedge mclk_i);
    sop_o = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      rx_valid_o = 1'b1;
      rx_data_o = 8'h10 + 8'(i);
      @(negedge mclk_i);
    end
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
    {eop_o, flag_o, fifo_full_o} = {1'b1, fl, full};
    @(negedge mclk_i);
    {eop_o, flag_o, fifo_full_o} = {1'b0, ~fl, 1'b0};
  endtask
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the receive status and acknowledge timer block.
// Assumes: Inputs change on the falling edge; the far side is the framer model.
// Notes: Ordinary packet cases are table rows; reset, stall, sticky and timer cases follow.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench
  import pdrx_pkg::*;
;
  typedef struct {int nb; logic [4:0] fl; logic full; logic [7:0] mx; logic [7:0] st; logic [3:0] irq;} pdrx_row_t;
  logic mclk_i, rstn_i, reg_wr_i, reg_rd_i, line_busy_i, tx_active_i, tx_launch_i, tx_start_o, tx_aborted_o;
  logic auto_resp_en_i, auto_retry_en_i, tx_end_i, ack_ok_i, ack_timeout_o, retry_req_o;
  logic sop_i, eop_i, rx_valid_i, rx_ready_o, out_valid_o, out_ready_i, rx_fifo_full_i;
  logic bad_irq, ovr_irq, drop_irq, pcol_irq;
  logic [15:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, rx_max_size_i, rx_data_i, out_data_o;
  logic [4:0] flag;
  logic [3:0] irq;
  int failures, checks, n;
  pdrx_row_t rows[9] = '{
    '{3, 5'b1_0000, 0, 8'h22, 8'h01, 4'b1000}, '{3, 5'b0_1000, 0, 8'h22, 8'h21, 4'b1000},
    '{3, 5'b0_0100, 0, 8'h22, 8'h41, 4'b1000}, '{5, 5'b1_1100, 0, 8'h04, 8'h08, 4'b1000},
    '{4, 5'b0_0000, 0, 8'h04, 8'h00, 4'b0000}, '{3, 5'b0_0000, 1, 8'h22, 8'h10, 4'b0100},
    '{3, 5'b0_0010, 0, 8'h22, 8'h02, 4'b0010}, '{3, 5'b0_0001, 0, 8'h22, 8'h04, 4'b0001},
    '{3, 5'b1_0010, 0, 8'h22, 8'h03, 4'b1010}};
  assign irq = {bad_irq, ovr_irq, drop_irq, pcol_irq};
  pdrx_status_timer i_pdrx_status_timer (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .line_busy_i(line_busy_i), .tx_active_i(tx_active_i), .tx_launch_i(tx_launch_i), .tx_start_o(tx_start_o),
    .tx_aborted_o(tx_aborted_o), .auto_resp_en_i(auto_resp_en_i), .auto_retry_en_i(auto_retry_en_i),
    .rx_max_size_i(rx_max_size_i), .sop_i(sop_i), .eop_i(eop_i), .crc_fail_i(flag[4]),
    .symbol_fault_i(flag[3]), .odd_nibble_i(flag[2]), .duplicate_i(flag[1]), .unexpected_reply_i(flag[0]),
    .rx_fifo_full_i(rx_fifo_full_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i), .tx_end_i(tx_end_i),
    .ack_ok_i(ack_ok_i), .ack_timeout_o(ack_timeout_o), .retry_req_o(retry_req_o),
    .bad_packet_interrupt_o(bad_irq), .buffer_overrun_interrupt_o(ovr_irq),
    .packet_dropped_interrupt_o(drop_irq), .protocol_error_interrupt_o(pcol_irq));
  pdrx_far_model i_pdrx_far_model (.mclk_i(mclk_i), .out_valid_i(out_valid_o), .out_data_i(out_data_o),
    .sop_o(sop_i), .eop_o(eop_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .flag_o(flag),
    .fifo_full_o(rx_fifo_full_i), .out_ready_o(out_ready_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic tick(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    tick(1);
    reg_rd_i = 1'b0;
    `CHK(reg_rdata_o, e)
    tick(1);
  endtask
  task automatic pulse_end();
    tx_end_i = 1'b1;
    tick(1);
    tx_end_i = 1'b0;
  endtask
  task automatic reset_values();
    rd_chk(PDRX_OFF_ACK_WAIT, 8'h64);
    rd_chk(PDRX_OFF_PKT_STAT, 8'h00);
    wr(PDRX_OFF_LINE_STAT, 8'hff);
    rd_chk(PDRX_OFF_LINE_STAT, 8'h00);
    rd_chk(16'h1a47, 8'h00);
    `CHK(rx_ready_o, 1'b1)
    $display("test reset values done");
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {rstn_i, reg_wr_i, reg_rd_i, line_busy_i, tx_active_i, tx_launch_i, tx_end_i, ack_ok_i} = 8'h00;
    {auto_resp_en_i, auto_retry_en_i, reg_addr_i, reg_wdata_i, rx_max_size_i} = {2'b11, 16'h0000, 8'h00, 8'h22};
    tick(3);
    rstn_i = 1'b1;
    tick(1);
    reset_values();
    foreach (rows[k])
    begin
      rx_max_size_i = rows[k].mx;
      wr(PDRX_OFF_PKT_STAT, 8'hff);
      pulse_end();
      i_pdrx_far_model.send_pkt(rows[k].nb, rows[k].fl, rows[k].full);
      `CHK(irq, rows[k].irq)
      rd_chk(PDRX_OFF_PKT_STAT, rows[k].st);
      $display("test row %0d done", k);
    end
    wr(PDRX_OFF_PKT_STAT, 8'h01);
    rd_chk(PDRX_OFF_PKT_STAT, 8'h02);
    i_pdrx_far_model.send_pkt(3, 5'b1_0000, 1'b0);
    rd_chk(PDRX_OFF_PKT_STAT, 8'h02);
    wr(PDRX_OFF_PKT_STAT, 8'hff);
    {auto_resp_en_i, auto_retry_en_i} = 2'b00;
    tick(1);
    rd_chk(PDRX_OFF_PKT_STAT, 8'hff);
    i_pdrx_far_model.send_pkt(3, 5'b1_0000, 1'b0);
    `CHK(irq, 4'b1000)
    {auto_resp_en_i, auto_retry_en_i} = 2'b11;
    tick(1);
    rd_chk(PDRX_OFF_PKT_STAT, 8'h00);
    $display("test sticky and modes done");
    i_pdrx_far_model.got_q.delete();
    i_pdrx_far_model.stall(1'b1);
    i_pdrx_far_model.send_pkt(3, 5'b0_0000, 1'b0);
    `CHK(irq, 4'b0100)
    `CHK(rx_ready_o, 1'b0)
    rd_chk(PDRX_OFF_PKT_STAT, 8'h10);
    i_pdrx_far_model.stall(1'b0);
    tick(4);
    `CHK(i_pdrx_far_model.got_q.size(), 2)
    `CHK({i_pdrx_far_model.got_q[0], i_pdrx_far_model.got_q[1]}, 16'h1011)
    `CHK(out_valid_o, 1'b0)
    $display("test stall done");
    for (int j = 0; j < 4; j++)
    begin
      {line_busy_i, tx_active_i} = 2'(j);
      tick(2);
      rd_chk(PDRX_OFF_LINE_STAT, {6'h00, line_busy_i & ~tx_active_i, line_busy_i});
    end
    tx_active_i = 1'b0;
    for (int b = 0; b < 2; b++)
    begin
      line_busy_i = 1'(b);
      tick(1);
      rd_chk(PDRX_OFF_LINE_STAT, {6'h00, line_busy_i, line_busy_i});
      tx_launch_i = 1'b1;
      tick(1);
      tx_launch_i = 1'b0;
      `CHK({tx_start_o, tx_aborted_o}, b ? 2'b01 : 2'b10)
    end
    line_busy_i = 1'b0;
    $display("test line and launch done");
    wr(PDRX_OFF_ACK_WAIT, 8'h5a);
    rd_chk(PDRX_OFF_ACK_WAIT, 8'h5a);
    pulse_end();
    n = 0;
    while (ack_timeout_o !== 1'b1 && n < 92000)
    begin
      tick(1);
      n++;
    end
    if (n == 92000)
      failures++;
    `CHK(n >= 89899 && n <= 90002, 1'b1)
    `CHK(retry_req_o, 1'b1)
    pulse_end();
    tick(50);
    ack_ok_i = 1'b1;
    tick(1);
    ack_ok_i = 1'b0;
    n = 0;
    repeat (2200)
    begin
      tick(1);
      n += int'(ack_timeout_o === 1'b1);
    end
    `CHK(n, 0)
    $display("test ack timer done");
    i_pdrx_far_model.send_pkt(3, 5'b1_0000, 1'b0);
    rstn_i = 1'b0;
    tick(3);
    rstn_i = 1'b1;
    tick(1);
    reset_values();
    give_verdict();
  end
endmodule
